// ==== rtl/fpc_top.sv ====
// flash program control: launch key, page buffer staging, flags, fuse-derived boot setup
`timescale 1ns/1ps
`include "fpc_regs.svh"

// Notes on behaviour
// - double_speed_fuse at 0 starts six-clock mode; at 1 standard mode.
// - boot_jump_fuse 1 clears boot map, start 0000h; 0 sets it, start F800h.
// - software never alters lock_fuse_bits; only the parallel programmer does.
// - a 128-byte page buffer stages every program of array, extra page, fuse.
// - page buffer is write-only to software.
// - programming launches count only when code runs from the boot array.
// - boot array never loaded or programmed; readable only by its own code.
// - external code reads user array per lock bits, never loads or programs.
// - key 5X then AX in flash_control launches the space_select operation.
// - latch_map_select routes data stores into the page buffer.
// - program_busy_flag set by hardware while programming; software cannot change it.
// - bad sequence sets error flag; software clears; good sequence clears.
// - loaded flag sets on first buffered byte, clears on successful launch.
// - store address bits 6-0 pick the byte, bits 15-7 the page.
// - latch_map_select overrides external_xdata_select.
// - space_select picks user, extra page, fuse byte or buffer reset.
// - with flash_control clear the user array is read-only via code reads.
// - programming starts the second cycle after the key pair.
// - 5X not followed by AX, or write with empty buffer, is an error.
// - only loaded bytes are programmed, at the last loaded page address.
// - stores to the buffer are ignored while programming runs.
module fpc_top #(
    parameter int PROG_CYCLES = `FPC_PROG_CYCLES,
    parameter int PAGE_BYTES = `FPC_PAGE_BYTES
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata_reg,
    input wire fpc_pkg::fpc_region_t exec_region,
    input wire logic other_instr,
    input wire fpc_pkg::fpc_store_t xstore,
    input wire logic external_xdata_select,
    output fpc_pkg::fpc_store_t xram_store_reg,
    output logic xram_ext_reg,
    input wire logic code_rd,
    input wire logic [15:0] code_addr,
    output logic code_rd_ok_reg,
    output fpc_pkg::fpc_target_t code_target_reg,
    input wire logic [7:0] fuse_cells,
    output logic x2_mode_reg,
    output logic boot_flash_map_reg,
    output logic [15:0] start_addr_reg,
    output logic cfg_valid_reg,
    output logic prog_busy_reg,
    output fpc_pkg::fpc_prog_t prog_reg,
    input wire logic [$clog2(PAGE_BYTES)-1:0] pb_rd_idx,
    output logic [7:0] pb_rd_data_reg,
    output logic pb_rd_loaded_reg
);
    localparam int AW = $clog2(PAGE_BYTES);
    localparam int CW = $clog2(PROG_CYCLES + 1);
    localparam logic [CW-1:0] START_LAST = CW'(`FPC_START_DLY - 1);
    localparam logic [CW-1:0] PROG_LAST = CW'(PROG_CYCLES - 1);

    // register hit decode, used by read and write paths
    function automatic logic hit(input logic [7:0] a, input logic [7:0] reg_addr);
        return a == reg_addr;
    endfunction : hit

    fpc_pkg::fpc_state_t state_reg, state_next;
    logic [CW-1:0] cnt_reg;
    logic [7:1] fctrl_reg;
    fpc_pkg::fpc_space_t armed_space_reg;
    logic sequence_error_flag_reg, loaded_reg;
    logic [8:0] page_reg;
    logic fctrl_wr, key_arm, key_go, pair_ok, launch_write, launch_clear, seq_bad;
    logic pb_wr, pb_clr, pb_any, in_prog, acc_ok;
    fpc_pkg::fpc_space_t new_space;
    fpc_pkg::fpc_target_t acc_target;

    // decode of flash_control writes and the launch key pair
    always_comb begin
        fctrl_wr = sfr_wr && hit(sfr_addr, `FPC_FCTRL_ADDR);
        new_space = fpc_pkg::fpc_space_t'(sfr_wdata[`FPC_SPACE_MSB:`FPC_SPACE_LSB]);
        key_arm = fctrl_wr && sfr_wdata[`FPC_KEY_MSB:`FPC_KEY_LSB] == `FPC_KEY_ARM;
        key_go = fctrl_wr && sfr_wdata[`FPC_KEY_MSB:`FPC_KEY_LSB] == `FPC_KEY_GO;
        // both writes must carry the same space selection
        pair_ok = state_reg == fpc_pkg::FPC_ST_ARMED && key_go && new_space == armed_space_reg;
        launch_write = pair_ok && new_space != fpc_pkg::FPC_SP_RESET
                       && exec_region == fpc_pkg::FPC_RG_BOOT && pb_any;
        launch_clear = pair_ok && new_space == fpc_pkg::FPC_SP_RESET
                       && exec_region == fpc_pkg::FPC_RG_BOOT;
        // interrupted pair, wrong second key, refused launch or stray go key
        seq_bad = (state_reg == fpc_pkg::FPC_ST_ARMED
                   && (other_instr || (fctrl_wr && !launch_write && !launch_clear)))
                  || (state_reg == fpc_pkg::FPC_ST_IDLE && key_go);
    end

    // launch sequencer: arm, one start cycle, then the busy window
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            fpc_pkg::FPC_ST_IDLE: begin
                if (key_arm) begin
                    state_next = fpc_pkg::FPC_ST_ARMED;
                end
            end
            fpc_pkg::FPC_ST_ARMED: begin
                if (launch_write) begin
                    state_next = fpc_pkg::FPC_ST_START;
                end else if (key_arm) begin
                    state_next = fpc_pkg::FPC_ST_ARMED;
                end else if (other_instr || fctrl_wr) begin
                    state_next = fpc_pkg::FPC_ST_IDLE;
                end
            end
            fpc_pkg::FPC_ST_START: begin
                if (cnt_reg == START_LAST) begin
                    state_next = fpc_pkg::FPC_ST_BUSY;
                end
            end
            fpc_pkg::FPC_ST_BUSY: begin
                if (cnt_reg == PROG_LAST) begin
                    state_next = fpc_pkg::FPC_ST_IDLE;
                end
            end
            default: state_next = fpc_pkg::FPC_ST_IDLE;
        endcase
    end

    // state, cycle counter and armed space
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            state_reg <= fpc_pkg::FPC_ST_IDLE;
            cnt_reg <= '0;
            armed_space_reg <= fpc_pkg::FPC_SP_USER;
        end else begin
            state_reg <= state_next;
            cnt_reg <= (state_next != state_reg) ? '0 : cnt_reg + CW'(1);
            if (key_arm && (state_reg == fpc_pkg::FPC_ST_IDLE || state_reg == fpc_pkg::FPC_ST_ARMED)) begin
                armed_space_reg <= new_space;
            end
        end
    end

    // busy flag follows the sequencer; software has no write path to it
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            prog_busy_reg <= 1'b0;
        end else begin
            prog_busy_reg <= state_next == fpc_pkg::FPC_ST_BUSY;
        end
    end

    // flash_control: key, map and space bits are plain storage
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            fctrl_reg <= 7'(`FPC_FCTRL_RST >> 1);
        end else if (fctrl_wr) begin
            fctrl_reg <= sfr_wdata[7:1];
        end
    end

    // sequence error: set wins over any clear in the same cycle
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            sequence_error_flag_reg <= 1'b0;
        end else if (seq_bad) begin
            sequence_error_flag_reg <= 1'b1;
        end else if (launch_write || launch_clear) begin
            sequence_error_flag_reg <= 1'b0;
        end else if (sfr_wr && hit(sfr_addr, `FPC_FSTAT_ADDR) && !sfr_wdata[`FPC_SEQUENCE_ERROR_FLAG_BIT]) begin
            sequence_error_flag_reg <= 1'b0;
        end
    end

    // buffer stores: map bit beats the xdata select; external code and busy are shut out
    always_comb begin
        in_prog = state_reg == fpc_pkg::FPC_ST_START || state_reg == fpc_pkg::FPC_ST_BUSY;
        pb_wr = xstore.valid && fctrl_reg[`FPC_MAP_BIT] && exec_region != fpc_pkg::FPC_RG_EXT
                && !in_prog;
        // automatic clear once a write has finished, or on request
        pb_clr = launch_clear || (state_reg == fpc_pkg::FPC_ST_BUSY && cnt_reg == PROG_LAST);
    end

    // loaded flag and last page address
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            loaded_reg <= 1'b0;
            page_reg <= 9'h000;
        end else begin
            if (pb_wr) begin
                loaded_reg <= 1'b1;
                page_reg <= xstore.addr[15:7];
            end else if (launch_write || launch_clear) begin
                loaded_reg <= 1'b0;
            end
        end
    end

    // ordinary data stores pass to external data memory only when not mapped
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            xram_store_reg <= '0;
            xram_ext_reg <= 1'b0;
        end else begin
            xram_store_reg <= xstore;
            xram_store_reg.valid <= xstore.valid && !fctrl_reg[`FPC_MAP_BIT];
            xram_ext_reg <= external_xdata_select;
        end
    end

    // job latched at launch; fuse writes carry a mask that spares the lock bits
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            prog_reg <= '0;
        end else if (launch_write) begin
            prog_reg.space <= new_space;
            prog_reg.page <= page_reg;
            prog_reg.mask <= (new_space == fpc_pkg::FPC_SP_FUSE) ? `FPC_FUSE_SW_MASK : `FPC_FULL_MASK;
        end
    end

    // register reads; buffer contents have no address here
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            sfr_rdata_reg <= 8'h00;
        end else if (sfr_rd && hit(sfr_addr, `FPC_FCTRL_ADDR)) begin
            sfr_rdata_reg <= {fctrl_reg, prog_busy_reg};
        end else if (sfr_rd && hit(sfr_addr, `FPC_FSTAT_ADDR)) begin
            sfr_rdata_reg <= {6'h00, sequence_error_flag_reg, loaded_reg};
        end else begin
            sfr_rdata_reg <= 8'h00;
        end
    end

    // boot setup is taken from the fuse cells at the first edge after reset release
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            cfg_valid_reg <= 1'b0;
            x2_mode_reg <= 1'b0;
            boot_flash_map_reg <= 1'b0;
            start_addr_reg <= `FPC_USER_START;
        end else if (!cfg_valid_reg) begin
            cfg_valid_reg <= 1'b1;
            x2_mode_reg <= !fuse_cells[`FPC_X2_BIT];
            boot_flash_map_reg <= !fuse_cells[`FPC_BLJ_BIT];
            start_addr_reg <= fuse_cells[`FPC_BLJ_BIT] ? `FPC_USER_START : `FPC_BOOT_START;
        end
    end

    fpc_page_buffer #(
        .DEPTH(PAGE_BYTES),
        .AW(AW)
    ) u_buf (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .wr_en(pb_wr),
        .wr_idx(xstore.addr[AW-1:0]),
        .wr_data(xstore.data),
        .clr(pb_clr),
        .rd_idx(pb_rd_idx),
        .rd_data_reg(pb_rd_data_reg),
        .rd_loaded_reg(pb_rd_loaded_reg),
        .any_loaded(pb_any)
    );

    fpc_access_check u_acc (
        .addr(code_addr),
        .region(exec_region),
        .space(fpc_pkg::fpc_space_t'(fctrl_reg[`FPC_SPACE_MSB:`FPC_SPACE_LSB])),
        .boot_map(boot_flash_map_reg),
        .lock_bits(fuse_cells[`FPC_LOCK_MSB:`FPC_LOCK_LSB]),
        .ok(acc_ok),
        .target(acc_target)
    );

    // code read answer, one cycle after the request
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            code_rd_ok_reg <= 1'b0;
            code_target_reg <= fpc_pkg::FPC_TG_USER;
        end else begin
            code_rd_ok_reg <= code_rd && acc_ok;
            code_target_reg <= acc_target;
        end
    end

    // helper: length of the current busy window
    logic [CW:0] busy_len_q;
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            busy_len_q <= '0;
        end else begin
            busy_len_q <= prog_busy_reg ? busy_len_q + (CW+1)'(1) : '0;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    sequence launch_s;
        launch_write;
    endsequence
    sequence ramp_s;
        !prog_busy_reg ##1 prog_busy_reg;
    endsequence

    busy_start_a: assert property (launch_s |=> ramp_s) else $error("busy not raised second cycle after key pair");
    busy_len_a: assert property ($fell(prog_busy_reg) |-> busy_len_q == (CW+1)'(PROG_CYCLES))
        else $error("busy window length wrong");
    busy_read_a: assert property (sfr_rd && hit(sfr_addr, `FPC_FCTRL_ADDR) |=> sfr_rdata_reg[0] == $past(prog_busy_reg))
        else $error("busy bit read wrong");
    sequence_error_flag_set_a: assert property (seq_bad |=> sequence_error_flag_reg) else $error("sequence error not flagged");
    sequence_error_flag_clr_a: assert property ((launch_write || launch_clear) && !seq_bad |=> !sequence_error_flag_reg)
        else $error("good sequence left error set");
    loaded_set_a: assert property (pb_wr |=> loaded_reg && page_reg == $past(xstore.addr[15:7]))
        else $error("buffer store not recorded");
    boot_only_a: assert property (state_reg == fpc_pkg::FPC_ST_START && $past(state_reg) == fpc_pkg::FPC_ST_ARMED
        |-> $past(exec_region) == fpc_pkg::FPC_RG_BOOT && $past(pb_any)) else $error("launch not from boot");
    store_block_a: assert property (in_prog && !pb_clr |=> u_buf.loaded_reg == $past(u_buf.loaded_reg))
        else $error("buffer changed while busy");
    map_route_a: assert property (xstore.valid && fctrl_reg[`FPC_MAP_BIT] |=> !xram_store_reg.valid)
        else $error("mapped store reached data memory");
    fuse_mask_a: assert property (launch_write && new_space == fpc_pkg::FPC_SP_FUSE |=> prog_reg.mask == `FPC_FUSE_SW_MASK)
        else $error("fuse job may alter lock bits");
    boot_cfg_a: assert property ($rose(cfg_valid_reg) |-> boot_flash_map_reg == !$past(fuse_cells[`FPC_BLJ_BIT])
        && x2_mode_reg == !$past(fuse_cells[`FPC_X2_BIT])) else $error("boot setup does not follow fuse");
endmodule : fpc_top

// ==== rtl/fpc_regs.svh ====
// register offsets, field positions, reset values and timing counts of the flash program control
`ifndef FPC_REGS_SVH
`define FPC_REGS_SVH

// special function register offsets
`define FPC_FCTRL_ADDR 8'hD1
`define FPC_FSTAT_ADDR 8'hD3

// flash_control fields
`define FPC_KEY_MSB 7
`define FPC_KEY_LSB 4
`define FPC_MAP_BIT 3
`define FPC_SPACE_MSB 2
`define FPC_SPACE_LSB 1
`define FPC_BUSY_BIT 0
`define FPC_FCTRL_RST 8'h00

// flash_status fields
`define FPC_SEQUENCE_ERROR_FLAG_BIT 1
`define FPC_LOADED_BIT 0
`define FPC_FSTAT_RST 8'h00

// launch key nibbles, first and second write
`define FPC_KEY_ARM 4'h5
`define FPC_KEY_GO 4'hA

// config_fuse_byte fields
`define FPC_X2_BIT 7
`define FPC_BLJ_BIT 6
`define FPC_LOCK_MSB 2
`define FPC_LOCK_LSB 0
`define FPC_LOCK_OPEN 3'h7
`define FPC_FUSE_SW_MASK 8'hF0
`define FPC_FULL_MASK 8'hFF

// start addresses and windows
`define FPC_USER_START 16'h0000
`define FPC_BOOT_START 16'hF800
`define FPC_EXTRA_PAGE_BASE 16'hFF80
`define FPC_FUSE_ADDR 16'h0000

// page buffer size and sequencing counts in core clock cycles
`define FPC_PAGE_BYTES 128
`define FPC_START_DLY 1
`define FPC_PROG_CYCLES 1000

`endif

// ==== rtl/fpc_pkg.sv ====
// types shared by the flash program control block
package fpc_pkg;

    // where the instruction being executed was fetched from
    typedef enum logic [1:0] {
        FPC_RG_USER = 2'h0,
        FPC_RG_BOOT = 2'h1,
        FPC_RG_EXT = 2'h2
    } fpc_region_t;

    // space_select encoding
    typedef enum logic [1:0] {
        FPC_SP_USER = 2'h0,
        FPC_SP_EXTRA_PAGE = 2'h1,
        FPC_SP_FUSE = 2'h2,
        FPC_SP_RESET = 2'h3
    } fpc_space_t;

    // array reached by a code-space read
    typedef enum logic [1:0] {
        FPC_TG_USER = 2'h0,
        FPC_TG_EXTRA_PAGE = 2'h1,
        FPC_TG_FUSE = 2'h2,
        FPC_TG_BOOT = 2'h3
    } fpc_target_t;

    // launch sequencer, gray along idle-armed-start-busy
    typedef enum logic [1:0] {
        FPC_ST_IDLE = 2'h0,
        FPC_ST_ARMED = 2'h1,
        FPC_ST_START = 2'h3,
        FPC_ST_BUSY = 2'h2
    } fpc_state_t;

    // external data store from the core
    typedef struct packed {
        logic valid;
        logic [15:0] addr;
        logic [7:0] data;
    } fpc_store_t;

    // programming job handed to the flash array
    typedef struct packed {
        fpc_space_t space;
        logic [8:0] page;
        logic [7:0] mask;
    } fpc_prog_t;

endpackage : fpc_pkg

// ==== rtl/fpc_page_buffer.sv ====
// write-only page buffer with per-byte loaded marks
`timescale 1ns/1ps
`include "fpc_regs.svh"
module fpc_page_buffer #(
    parameter int DEPTH = `FPC_PAGE_BYTES,
    parameter int AW = $clog2(DEPTH)
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_idx,
    input wire logic [7:0] wr_data,
    input wire logic clr,
    input wire logic [AW-1:0] rd_idx,
    output logic [7:0] rd_data_reg,
    output logic rd_loaded_reg,
    output logic any_loaded
);
    logic [7:0] mem [DEPTH];
    logic [DEPTH-1:0] loaded_reg;

    // storage has no reset; the loaded marks say which bytes mean anything
    always_ff @(posedge core_clk) begin
        if (wr_en) begin
            mem[wr_idx] <= wr_data;
        end
    end

    // a store in the clearing cycle survives so no byte is silently lost
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            loaded_reg <= '0;
        end else begin
            for (int i = 0; i < DEPTH; i++) begin
                if (wr_en && wr_idx == AW'(i)) begin
                    loaded_reg[i] <= 1'b1;
                end else if (clr) begin
                    loaded_reg[i] <= 1'b0;
                end
            end
        end
    end

    // only the flash array reads back; no software path exists
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            rd_data_reg <= 8'h00;
            rd_loaded_reg <= 1'b0;
        end else begin
            rd_data_reg <= mem[rd_idx];
            rd_loaded_reg <= loaded_reg[rd_idx];
        end
    end

    assign any_loaded = |loaded_reg;
endmodule : fpc_page_buffer

// ==== rtl/fpc_access_check.sv ====
// code-space read permission and target decode
`timescale 1ns/1ps
`include "fpc_regs.svh"
module fpc_access_check (
    input wire logic [15:0] addr,
    input wire fpc_pkg::fpc_region_t region,
    input wire fpc_pkg::fpc_space_t space,
    input wire logic boot_map,
    input wire logic [2:0] lock_bits,
    output logic ok,
    output fpc_pkg::fpc_target_t target
);
    // decide target and permission for one code read
    function automatic logic [2:0] decide(input logic [15:0] a, input fpc_pkg::fpc_region_t rg,
                                          input fpc_pkg::fpc_space_t sp, input logic bm,
                                          input logic [2:0] lk);
        logic user_ok;
        user_ok = (rg != fpc_pkg::FPC_RG_EXT) || (lk == `FPC_LOCK_OPEN);
        if (bm && sp == fpc_pkg::FPC_SP_USER && a >= `FPC_BOOT_START) begin
            // boot flash overlays the user space only, so extra page and fuse reads stay reachable
            return {rg == fpc_pkg::FPC_RG_BOOT, fpc_pkg::FPC_TG_BOOT};
        end
        case (sp)
            fpc_pkg::FPC_SP_USER: return {user_ok, fpc_pkg::FPC_TG_USER};
            fpc_pkg::FPC_SP_EXTRA_PAGE: return {user_ok && a >= `FPC_EXTRA_PAGE_BASE, fpc_pkg::FPC_TG_EXTRA_PAGE};
            fpc_pkg::FPC_SP_FUSE: return {user_ok && a == `FPC_FUSE_ADDR, fpc_pkg::FPC_TG_FUSE};
            default: return {1'b0, fpc_pkg::FPC_TG_USER};
        endcase
    endfunction : decide

    logic [2:0] res;

    // external code reads of the user array follow the lock bits
    always_comb begin
        res = decide(addr, region, space, boot_map, lock_bits);
        ok = res[2];
        target = fpc_pkg::fpc_target_t'(res[1:0]);
    end
endmodule : fpc_access_check

// ==== sim/fpc_core_model.sv ====
// processor core model issuing register, store and fetch traffic
`timescale 1ns/1ps
module fpc_core_model (
    input wire logic core_clk,
    input wire logic [7:0] sfr_rdata_reg,
    output logic sfr_wr,
    output logic sfr_rd,
    output logic [7:0] sfr_addr,
    output logic [7:0] sfr_wdata,
    output fpc_pkg::fpc_region_t exec_region,
    output logic other_instr,
    output fpc_pkg::fpc_store_t xstore,
    output logic external_xdata_select,
    output logic code_rd,
    output logic [15:0] code_addr
);
    // idle bus at time zero, running from the boot array
    initial begin
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
        sfr_addr = 8'h00;
        sfr_wdata = 8'h00;
        exec_region = fpc_pkg::FPC_RG_BOOT;
        other_instr = 1'b0;
        xstore = '0;
        external_xdata_select = 1'b1;
        code_rd = 1'b0;
        code_addr = 16'h0000;
    end
    // one write per call, so a key pair goes out with nothing between
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        sfr_wr <= 1'b1;
        sfr_addr <= a;
        sfr_wdata <= d;
        @(posedge core_clk);
        sfr_wr <= 1'b0;
    endtask : wr
    // read data lands one cycle after the strobe, so busy is never seen early
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        sfr_rd <= 1'b1;
        sfr_addr <= a;
        @(posedge core_clk);
        sfr_rd <= 1'b0;
        #1 d = sfr_rdata_reg;
    endtask : rd
    // data store through the pointer
    task automatic st(input logic [15:0] a, input logic [7:0] d);
        @(posedge core_clk);
        xstore <= '{1'b1, a, d};
        @(posedge core_clk);
        xstore.valid <= 1'b0;
        #1;
    endtask : st
    // stray instruction that breaks a key pair
    task automatic stray();
        @(posedge core_clk);
        other_instr <= 1'b1;
        @(posedge core_clk);
        other_instr <= 1'b0;
    endtask : stray
    // code-space read; answer settles one cycle later
    task automatic cr(input logic [15:0] a);
        @(posedge core_clk);
        code_rd <= 1'b1;
        code_addr <= a;
        @(posedge core_clk);
        code_rd <= 1'b0;
        #1;
    endtask : cr
endmodule : fpc_core_model

// ==== sim/tb_flash_program_control.sv ====
// register-level testbench of the flash program control
`timescale 1ns/1ps
module tb_flash_program_control;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [6:0] pb_rd_idx = 7'h00;
    logic [7:0] fuse = 8'h3F;
    logic [7:0] d;
    int err_total = 0;
    int comparisons = 0;
    int n;
    wire logic sfr_wr, sfr_rd, other_instr, ext_sel, code_rd, x2, bmap, ok, busy, pbl, cfgv, extq;
    wire logic [7:0] sfr_addr, sfr_wdata, rdata, pbd;
    wire logic [15:0] code_addr, start;
    wire fpc_pkg::fpc_region_t region;
    wire fpc_pkg::fpc_store_t xstore, xram;
    wire fpc_pkg::fpc_target_t tgt;
    wire fpc_pkg::fpc_prog_t prog;
    always #2.5 core_clk = ~core_clk;
    fpc_core_model core_u (.core_clk(core_clk), .sfr_rdata_reg(rdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
        .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .exec_region(region), .other_instr(other_instr),
        .xstore(xstore), .external_xdata_select(ext_sel), .code_rd(code_rd), .code_addr(code_addr));
    // short busy time keeps the run brief
    fpc_top #(.PROG_CYCLES(8)) dut_u (.core_clk(core_clk), .reset_n(reset_n), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata_reg(rdata),
        .exec_region(region), .other_instr(other_instr), .xstore(xstore), .external_xdata_select(ext_sel),
        .xram_store_reg(xram), .xram_ext_reg(extq), .code_rd(code_rd), .code_addr(code_addr),
        .code_rd_ok_reg(ok), .code_target_reg(tgt), .fuse_cells(fuse), .x2_mode_reg(x2),
        .boot_flash_map_reg(bmap), .start_addr_reg(start), .cfg_valid_reg(cfgv), .prog_busy_reg(busy),
        .prog_reg(prog), .pb_rd_idx(pb_rd_idx), .pb_rd_data_reg(pbd), .pb_rd_loaded_reg(pbl));
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
        comparisons++;
        if (s !== e) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        core_u.rd(a, d);
        chk("sfr", {8'h00, e}, {8'h00, d});
    endtask : rdchk
    // buffer byte and its loaded mark, one cycle after the index
    task automatic pbchk(input logic [6:0] i, input logic [7:0] e, input logic l);
        @(posedge core_clk);
        pb_rd_idx <= i;
        @(posedge core_clk);
        // an unloaded byte holds no defined data, so only its mark is compared
        #1 chk("page_buffer", {7'h00, l, l ? e : 8'h00}, {7'h00, pbl, l ? pbd : 8'h00});
    endtask : pbchk
    task automatic summarize();
        if (err_total == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : summarize
    initial begin
        repeat (8) @(posedge core_clk);
        reset_n <= 1'b1;
        @(posedge core_clk);
        #1 chk("x2_mode", 16'h0001, {15'h0, x2});
        chk("start", 16'hF800, start);
        chk("boot_map", 16'h0001, {15'h0, bmap});
        rdchk(8'hD1, 8'h00);
        rdchk(8'hD3, 8'h00);
        rdchk(8'h80, 8'h00);
        // write launch with nothing loaded, then software clear
        core_u.wr(8'hD1, 8'h50);
        core_u.wr(8'hD1, 8'hA0);
        rdchk(8'hD3, 8'h02);
        core_u.wr(8'hD3, 8'h00);
        rdchk(8'hD3, 8'h00);
        // mapped stores land in the buffer; the later page wins
        core_u.wr(8'hD1, 8'h08);
        core_u.st(16'h1234, 8'h55);
        core_u.st(16'h12FF, 8'hAA);
        rdchk(8'hD3, 8'h01);
        pbchk(7'h34, 8'h55, 1'b1);
        pbchk(7'h7F, 8'hAA, 1'b1);
        // broken pair, then a good one
        core_u.wr(8'hD1, 8'h58);
        core_u.stray();
        core_u.wr(8'hD1, 8'hA8);
        rdchk(8'hD3, 8'h03);
        core_u.wr(8'hD1, 8'h58);
        core_u.wr(8'hD1, 8'hA8);
        #1 chk("prog", {5'h00, 2'h0, 9'h025}, {5'h00, prog.space, prog.page});
        chk("prog_mask", 16'h00FF, {8'h00, prog.mask});
        chk("busy_early", 16'h0000, {15'h0, busy});
        @(posedge core_clk);
        #1 chk("busy", 16'h0001, {15'h0, busy});
        core_u.wr(8'hD1, 8'h08);
        core_u.st(16'h1234, 8'h11);
        core_u.rd(8'hD1, d);
        chk("busy_bit", 16'h0001, {15'h0, d[0]});
        pbchk(7'h34, 8'h55, 1'b1);
        n = 0;
        while (busy === 1'b1 && n < 40) begin
            @(posedge core_clk);
            n++;
        end
        chk("busy_end", 16'h0000, {15'h0, busy});
        rdchk(8'hD3, 8'h00);
        // launches from user array and external code are refused
        core_u.wr(8'hD1, 8'h08);
        core_u.st(16'h0005, 8'h77);
        core_u.exec_region = fpc_pkg::FPC_RG_EXT;
        core_u.st(16'h0006, 8'h88);
        pbchk(7'h06, 8'h00, 1'b0);
        for (int r = 0; r < 2; r++) begin
            core_u.exec_region = r ? fpc_pkg::FPC_RG_EXT : fpc_pkg::FPC_RG_USER;
            core_u.wr(8'hD1, 8'h50);
            core_u.wr(8'hD1, 8'hA0);
            rdchk(8'hD3, 8'h03);
            chk("busy_refused", 16'h0000, {15'h0, busy});
        end
        // buffer reset from boot code
        core_u.exec_region = fpc_pkg::FPC_RG_BOOT;
        core_u.wr(8'hD1, 8'h56);
        core_u.wr(8'hD1, 8'hA6);
        rdchk(8'hD3, 8'h00);
        // unmapped store goes to ordinary data memory
        core_u.wr(8'hD1, 8'h02);
        core_u.st(16'h0100, 8'h3C);
        chk("xram", {6'h0, 2'h3, 8'h3C}, {6'h0, extq, xram.valid, xram.data});
        core_u.cr(16'hFF80);
        chk("code_rd", 16'h0101, {7'h0, ok, 6'h0, tgt});
        // boot flash window refused to user array code
        core_u.wr(8'hD1, 8'h00);
        core_u.exec_region = fpc_pkg::FPC_RG_USER;
        core_u.cr(16'hF800);
        chk("code_rd_boot", 16'h0003, {7'h0, ok, 6'h0, tgt});
        // fuse job spares the lock bits; a reset in mid-job then picks up new fuse cells
        core_u.exec_region = fpc_pkg::FPC_RG_BOOT;
        core_u.wr(8'hD1, 8'h0C);
        core_u.st(16'h0000, 8'h5A);
        core_u.wr(8'hD1, 8'h54);
        core_u.wr(8'hD1, 8'hA4);
        #1 chk("fuse_job", 16'hF002, {prog.mask, 6'h00, prog.space});
        @(posedge core_clk);
        reset_n <= 1'b0;
        fuse <= 8'hC0;
        repeat (3) @(posedge core_clk);
        reset_n <= 1'b1;
        @(posedge core_clk);
        #1 chk("boot_reset", 16'h0001, {13'h0, x2, bmap, cfgv});
        chk("start_reset", 16'h0000, start);
        // external code with lock bits programmed may not read the user array
        core_u.exec_region = fpc_pkg::FPC_RG_EXT;
        core_u.cr(16'h0010);
        chk("code_rd_lock", 16'h0000, {7'h0, ok, 6'h0, tgt});
        summarize();
    end
endmodule : tb_flash_program_control
